// >>> logic/cemseq_pkg.sv
package cemseq_pkg;

  // clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_TIME_US  = 1000;
  localparam int unsigned TICK_CYCLES   = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 20;

  // register offsets
  localparam logic [7:0] ADDR_PROFILE_STATUS_ONE  = 8'h12;
  localparam logic [7:0] ADDR_EMULATION_CONFIG    = 8'h16;
  localparam logic [7:0] ADDR_CURRENT_LIMIT       = 8'h17;
  localparam logic [7:0] ADDR_CHARGE_THRESHOLD    = 8'h18;
  localparam logic [7:0] ADDR_PROFILE_ENABLE      = 8'h19;
  localparam logic [7:0] ADDR_HS_SWITCH_CONFIG    = 8'h25;
  localparam logic [7:0] ADDR_PROFILE_TIMEOUT0    = 8'h30;
  localparam logic [7:0] ADDR_CUSTOM_EMU_CONFIG   = 8'h40;
  localparam logic [7:0] ADDR_CUSTOM_LIMIT_CONFIG = 8'h51;

  // field positions
  localparam int unsigned EMU_RETRY_BIT    = 0;
  localparam int unsigned EMU_TIMEOUT_BIT  = 1;
  localparam int unsigned CUST_ENABLE_BIT  = 4;
  localparam int unsigned CUST_FIRST_BIT   = 5;
  localparam int unsigned HS_CLOSE_BIT     = 0;
  localparam int unsigned R2MIN_LSB        = 2;
  localparam int unsigned STAT_NO_HANDSHAKE_FLAG_BIT   = 0;
  localparam int unsigned STAT_DCP_BIT     = 1;
  localparam int unsigned STAT_ACCEPT_BIT  = 2;
  localparam int unsigned STAT_PROF_LSB    = 4;

  // reset values
  localparam logic [7:0] EMULATION_CONFIG_RST = 8'h03;
  localparam logic [7:0] CURRENT_LIMIT_RST    = 8'h07;
  localparam logic [7:0] CHARGE_THRESHOLD_RST = 8'h10;
  localparam logic [7:0] PROFILE_ENABLE_RST   = 8'hFF;
  localparam logic [7:0] HS_SWITCH_CONFIG_RST = 8'h00;
  localparam logic [7:0] PROFILE_TIMEOUT_RST  = 8'h33;
  localparam logic [7:0] CUSTOM_EMU_RST       = 8'h03;
  localparam logic [7:0] CUSTOM_LIMIT_RST     = 8'h00;

  // current limit code that stands for 1.5 A
  localparam logic [3:0] CURRENT_LIMIT_SETTING_1A5_CODE = 4'h7;

  // profile codes and positions
  localparam logic [3:0] PROF_LEGACY1 = 4'h0;
  localparam logic [3:0] PROF_DCP     = 4'h1;
  localparam logic [3:0] PROF_LEGACY2 = 4'h2;
  localparam logic [3:0] PROF_CUSTOM  = 4'h8;
  localparam logic [3:0] POS_LAST     = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_NEXT,
    ST_RESET,
    ST_APPLY,
    ST_ACCEPT,
    ST_NOHS
  } cemseq_state_e;

  // data line drive bundle
  typedef struct packed {
    logic       charger_short_on;
    logic       pulldown_on;
    logic       sig_valid;
    logic [3:0] profile;
  } cemseq_drive_s;

endpackage

// >>> logic/cemseq_top.sv
`timescale 1ns/1ps
`default_nettype none

module cemseq_top #(
  parameter int unsigned TICK_CYCLES       = cemseq_pkg::TICK_CYCLES,
  parameter int unsigned DISCHARGE_TICKS   = 10,
  parameter int unsigned RESET_HOLD_TICKS  = 20,
  parameter int unsigned TIMEOUT_UNIT_TICKS = 100
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  // mode controls
  input  wire logic                      emulation_enable_control,
  input  wire logic                      mode_select_high,
  input  wire logic                      mode_select_low,
  input  wire logic                      port_power_enable,
  // measured load
  input  wire logic [7:0]                bus_load_current,
  // register port
  input  wire logic                      reg_wr_en,
  input  wire logic                      reg_rd_en,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  // port power and data lines
  output logic                           port_switch_closed,
  output logic                           vbus_discharge_on,
  output cemseq_pkg::cemseq_drive_s      line_drive,
  output logic                           hs_switch_closed,
  output logic                           cc_limit_mode
);

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]                   emu_cfg_r;
  logic [7:0]                   current_limit_setting_r;
  logic [7:0]                   thresh_r;
  logic [7:0]                   prof_en_r;
  logic [7:0]                   hs_cfg_r;
  logic [7:0]                   cust_cfg_r;
  logic [7:0]                   cust_lim_r;
  logic [7:0]                   tmo_r [4];
  logic [7:0]                   status_r;
  logic [7:0]                   rdata_nxt;
  cemseq_pkg::cemseq_state_e    state_r;
  logic [3:0]                   pos_r;
  logic [3:0]                   prof_r;
  logic [cemseq_pkg::TMR_W-1:0] tmr_r;
  logic [cemseq_pkg::TMR_W-1:0] rst_cnt_r;
  logic [31:0]                  tick_cnt_r;
  logic                         tick;
  logic                         run;
  logic [3:0]                   cur_prof;
  logic                         cur_en;
  logic [3:0]                   tmo_code;
  logic [cemseq_pkg::TMR_W-1:0] tmo_load;
  logic                         tmo_en;
  logic                         retry_en;
  logic                         cust_first;
  logic                         above;
  logic                         expire;
  logic                         low_limit;
  logic [3:0]                   r2min;
  logic                         r2_cc;
  logic                         applied;

  // software writes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      emu_cfg_r  <= cemseq_pkg::EMULATION_CONFIG_RST;
      current_limit_setting_r     <= cemseq_pkg::CURRENT_LIMIT_RST;
      thresh_r   <= cemseq_pkg::CHARGE_THRESHOLD_RST;
      prof_en_r  <= cemseq_pkg::PROFILE_ENABLE_RST;
      hs_cfg_r   <= cemseq_pkg::HS_SWITCH_CONFIG_RST;
      cust_cfg_r <= cemseq_pkg::CUSTOM_EMU_RST;
      cust_lim_r <= cemseq_pkg::CUSTOM_LIMIT_RST;
      for (int i = 0; i < 4; i++) begin
        tmo_r[i] <= cemseq_pkg::PROFILE_TIMEOUT_RST;
      end
    end else if (reg_wr_en) begin
      case (reg_addr)
        cemseq_pkg::ADDR_EMULATION_CONFIG:    emu_cfg_r  <= reg_wdata;
        cemseq_pkg::ADDR_CURRENT_LIMIT:       current_limit_setting_r     <= reg_wdata;
        cemseq_pkg::ADDR_CHARGE_THRESHOLD:    thresh_r   <= reg_wdata;
        cemseq_pkg::ADDR_PROFILE_ENABLE:      prof_en_r  <= reg_wdata;
        cemseq_pkg::ADDR_HS_SWITCH_CONFIG:    hs_cfg_r   <= reg_wdata;
        cemseq_pkg::ADDR_CUSTOM_EMU_CONFIG:   cust_cfg_r <= reg_wdata;
        cemseq_pkg::ADDR_CUSTOM_LIMIT_CONFIG: cust_lim_r <= reg_wdata;
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (reg_addr == cemseq_pkg::ADDR_PROFILE_TIMEOUT0 + 8'(i)) begin
              tmo_r[i] <= reg_wdata;
            end
          end
        end
      endcase
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      cemseq_pkg::ADDR_PROFILE_STATUS_ONE:  rdata_nxt = status_r;
      cemseq_pkg::ADDR_EMULATION_CONFIG:    rdata_nxt = emu_cfg_r;
      cemseq_pkg::ADDR_CURRENT_LIMIT:       rdata_nxt = current_limit_setting_r;
      cemseq_pkg::ADDR_CHARGE_THRESHOLD:    rdata_nxt = thresh_r;
      cemseq_pkg::ADDR_PROFILE_ENABLE:      rdata_nxt = prof_en_r;
      cemseq_pkg::ADDR_HS_SWITCH_CONFIG:    rdata_nxt = hs_cfg_r;
      cemseq_pkg::ADDR_CUSTOM_EMU_CONFIG:   rdata_nxt = cust_cfg_r;
      cemseq_pkg::ADDR_CUSTOM_LIMIT_CONFIG: rdata_nxt = cust_lim_r;
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (reg_addr == cemseq_pkg::ADDR_PROFILE_TIMEOUT0 + 8'(i)) begin
            rdata_nxt = tmo_r[i];
          end
        end
      end
    endcase
  end

  // registered read data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decode and profile order
  assign run = emulation_enable_control
             & ~(mode_select_high & mode_select_low)
             & port_power_enable;
  assign cust_first = cust_cfg_r[cemseq_pkg::CUST_FIRST_BIT];
  assign retry_en   = emu_cfg_r[cemseq_pkg::EMU_RETRY_BIT];
  assign tmo_en     = emu_cfg_r[cemseq_pkg::EMU_TIMEOUT_BIT];

  // position to profile, custom first or last
  always_comb begin
    if (cust_first) begin
      cur_prof = (pos_r == 4'h0) ? cemseq_pkg::PROF_CUSTOM : pos_r - 4'h1;
    end else begin
      cur_prof = pos_r;
    end
    if (cur_prof == cemseq_pkg::PROF_CUSTOM) begin
      cur_en = cust_cfg_r[cemseq_pkg::CUST_ENABLE_BIT];
    end else begin
      cur_en = prof_en_r[cur_prof[2:0]];
    end
  end

  // per-profile timeout code and tick load
  always_comb begin
    if (prof_r == cemseq_pkg::PROF_CUSTOM) begin
      tmo_code = cust_cfg_r[3:0];
    end else if (prof_r[0]) begin
      tmo_code = tmo_r[prof_r[2:1]][7:4];
    end else begin
      tmo_code = tmo_r[prof_r[2:1]][3:0];
    end
    tmo_load = cemseq_pkg::TMR_W'((tmo_code + 5'h01) * TIMEOUT_UNIT_TICKS);
  end

  ////////////////////////////////////////////////////////////////////
  // timebase tick
  always_ff @(posedge core_clk) begin
    if (srst || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  assign above  = bus_load_current > thresh_r;
  assign expire = (state_r == cemseq_pkg::ST_APPLY) && tmo_en && (tmr_r == '0);

  ////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge core_clk) begin
    if (srst || !run) begin
      state_r <= cemseq_pkg::ST_IDLE;
      pos_r   <= 4'h0;
      prof_r  <= 4'h0;
    end else begin
      unique case (state_r)
        cemseq_pkg::ST_IDLE: begin
          state_r <= cemseq_pkg::ST_NEXT;
          pos_r   <= 4'h0;
        end
        cemseq_pkg::ST_NEXT: begin
          if (pos_r > cemseq_pkg::POS_LAST) begin
            pos_r   <= 4'h0;
            state_r <= retry_en ? cemseq_pkg::ST_NEXT
                                : cemseq_pkg::ST_NOHS;
          end else if (cur_en) begin
            prof_r  <= cur_prof;
            state_r <= cemseq_pkg::ST_RESET;
          end else begin
            pos_r <= pos_r + 4'h1;
          end
        end
        cemseq_pkg::ST_RESET: begin
          if (rst_cnt_r >= cemseq_pkg::TMR_W'(RESET_HOLD_TICKS)) begin
            state_r <= cemseq_pkg::ST_APPLY;
          end
        end
        cemseq_pkg::ST_APPLY: begin
          if (expire && above) begin
            state_r <= cemseq_pkg::ST_ACCEPT;
          end else if (expire) begin
            pos_r   <= pos_r + 4'h1;
            state_r <= cemseq_pkg::ST_NEXT;
          end
        end
        cemseq_pkg::ST_ACCEPT: state_r <= cemseq_pkg::ST_ACCEPT;
        cemseq_pkg::ST_NOHS:   state_r <= cemseq_pkg::ST_NOHS;
      endcase
    end
  end

  // emulation reset elapsed ticks
  always_ff @(posedge core_clk) begin
    if (srst || state_r != cemseq_pkg::ST_RESET) begin
      rst_cnt_r <= '0;
    end else if (tick) begin
      rst_cnt_r <= rst_cnt_r + 1'b1;
    end
  end

  // emulation timer, loaded as each profile starts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tmr_r <= '0;
    end else if (state_r == cemseq_pkg::ST_RESET) begin
      tmr_r <= tmo_load;
    end else if (state_r == cemseq_pkg::ST_APPLY && tick && tmr_r != '0) begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  // profile status
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_r <= 8'h00;
    end else begin
      status_r <= 8'h00;
      status_r[cemseq_pkg::STAT_NO_HANDSHAKE_FLAG_BIT] <= (state_r == cemseq_pkg::ST_NOHS);
      if (state_r == cemseq_pkg::ST_ACCEPT) begin
        status_r[cemseq_pkg::STAT_ACCEPT_BIT] <= 1'b1;
        status_r[cemseq_pkg::STAT_DCP_BIT] <= (prof_r == cemseq_pkg::PROF_DCP);
        status_r[cemseq_pkg::STAT_PROF_LSB +: 4] <= prof_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign applied   = (state_r == cemseq_pkg::ST_APPLY) || (state_r == cemseq_pkg::ST_ACCEPT);
  assign low_limit = current_limit_setting_r[3:0] <= cemseq_pkg::CURRENT_LIMIT_SETTING_1A5_CODE;
  assign r2min     = {1'b0, cust_lim_r[cemseq_pkg::R2MIN_LSB +: 3]};
  assign r2_cc     = low_limit && (r2min > current_limit_setting_r[3:0]);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      port_switch_closed <= 1'b0;
      vbus_discharge_on  <= 1'b0;
      line_drive         <= '0;
      hs_switch_closed   <= 1'b0;
      cc_limit_mode      <= 1'b0;
    end else begin
      port_switch_closed <= applied || (state_r == cemseq_pkg::ST_NOHS);
      vbus_discharge_on  <= (state_r == cemseq_pkg::ST_RESET) &&
                            (rst_cnt_r < cemseq_pkg::TMR_W'(DISCHARGE_TICKS));
      line_drive.pulldown_on <= (state_r == cemseq_pkg::ST_RESET);
      line_drive.sig_valid   <= applied;
      line_drive.profile     <= applied ? prof_r : 4'h0;
      // short stays whatever the far end drives on either line
      line_drive.charger_short_on <= applied &&
          (prof_r == cemseq_pkg::PROF_DCP || prof_r == cemseq_pkg::PROF_LEGACY2);
      hs_switch_closed <= (applied || state_r == cemseq_pkg::ST_NOHS) &&
                          hs_cfg_r[cemseq_pkg::HS_CLOSE_BIT];
      if (state_r == cemseq_pkg::ST_NOHS) begin
        cc_limit_mode <= r2_cc;
      end else if (state_r == cemseq_pkg::ST_ACCEPT || (applied && !tmo_en)) begin
        cc_limit_mode <= (prof_r == cemseq_pkg::PROF_DCP ||
                          prof_r == cemseq_pkg::PROF_LEGACY2) ? low_limit : r2_cc;
      end else begin
        cc_limit_mode <= applied && low_limit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_expire_low;
    expire && !above;
  endsequence
  sequence s_expire_high;
    expire && above;
  endsequence

  chk_reject_next: assert property (@(posedge core_clk) disable iff (srst)
    s_expire_low ##0 run |=> state_r == cemseq_pkg::ST_NEXT)
    else $error("rejected profile did not advance");
  chk_accept_stop: assert property (@(posedge core_clk) disable iff (srst)
    s_expire_high ##0 run ##1 run [*2] |=> state_r == cemseq_pkg::ST_ACCEPT)
    else $error("accepted profile not held");
  chk_timer_load: assert property (@(posedge core_clk) disable iff (srst)
    $rose(state_r == cemseq_pkg::ST_APPLY) |-> tmr_r == tmo_load)
    else $error("emulation timer not loaded");
  chk_reset_lines: assert property (@(posedge core_clk) disable iff (srst)
    state_r == cemseq_pkg::ST_RESET && run |=> line_drive.pulldown_on && !port_switch_closed)
    else $error("reset drive wrong");
  chk_nohs_flag: assert property (@(posedge core_clk) disable iff (srst)
    state_r == cemseq_pkg::ST_NOHS |=> status_r[cemseq_pkg::STAT_NO_HANDSHAKE_FLAG_BIT])
    else $error("no-handshake flag missing");
  chk_nohs_clean: assert property (@(posedge core_clk) disable iff (srst)
    state_r == cemseq_pkg::ST_NOHS |=> !line_drive.sig_valid && !line_drive.charger_short_on)
    else $error("signature left in no-handshake");
  chk_abort_idle: assert property (@(posedge core_clk) disable iff (srst)
    !run |=> state_r == cemseq_pkg::ST_IDLE ##1 !port_switch_closed)
    else $error("abort did not idle");
  chk_custom_gate: assert property (@(posedge core_clk) disable iff (srst)
    state_r == cemseq_pkg::ST_APPLY && prof_r == cemseq_pkg::PROF_CUSTOM
      |-> cust_cfg_r[cemseq_pkg::CUST_ENABLE_BIT])
    else $error("custom applied while disabled");
  chk_dcp_short: assert property (@(posedge core_clk) disable iff (srst)
    applied && prof_r == cemseq_pkg::PROF_DCP && $stable(state_r)
      |=> line_drive.charger_short_on && port_switch_closed)
    else $error("dcp short missing");

endmodule

`default_nettype wire

// >>> tb/cemseq_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

// portable device: draws charge current for one chosen profile only
module cemseq_dev_model (
  // clock
  input  wire logic                      core_clk,
  // port side as the device sees it
  input  wire cemseq_pkg::cemseq_drive_s line_drive,
  input  wire logic                      port_switch_closed,
  // scenario controls
  input  wire logic                      attached,
  input  wire logic [3:0]                accept_prof,
  // load current back into the port
  output logic      [7:0]                bus_load_current
);
  logic       match;
  logic [3:0] wait_r = 4'h0;

  // the device only reacts to its own signature with power present
  assign match = attached & port_switch_closed & line_drive.sig_valid
                 & (line_drive.profile == accept_prof);

  // a slow device: charging starts some cycles after the signature
  always_ff @(posedge core_clk) begin
    if (!match) begin
      wait_r <= 4'h0;
    end else if (wait_r != 4'hF) begin
      wait_r <= wait_r + 4'h1;
    end
  end

  // no power, no load; a heavy draw once charging starts, a small standby draw below the threshold otherwise
  assign bus_load_current = !port_switch_closed ? 8'h00 :
                            (wait_r > 4'h5)     ? 8'h40 : 8'h03;
endmodule

`default_nettype wire

// >>> tb/cemseq_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); \
  end \
end

module cemseq_top_tb;
  localparam int TK   = 4;
  localparam int UNIT = 2;

  logic                      core_clk    = 1'b0;
  logic                      srst        = 1'b1;
  logic                      en          = 1'b1;
  logic                      sel_hi      = 1'b0;
  logic                      sel_lo      = 1'b0;
  logic                      pwr         = 1'b0;
  logic                      wr          = 1'b0;
  logic                      rd          = 1'b0;
  logic [7:0]                addr        = 8'h00;
  logic [7:0]                wdata       = 8'h00;
  logic                      attached    = 1'b0;
  logic [3:0]                accept_prof = 4'h0;
  logic [7:0]                rdata;
  logic [7:0]                load;
  logic                      sw;
  logic                      dis;
  logic                      hs;
  logic                      cc;
  cemseq_pkg::cemseq_drive_s drv;
  int                        errors          = 0;
  int                        samples_checked = 0;

  cemseq_top #(.TICK_CYCLES(TK), .DISCHARGE_TICKS(2), .RESET_HOLD_TICKS(4),
               .TIMEOUT_UNIT_TICKS(UNIT)) u_dut (
    .core_clk(core_clk), .srst(srst), .emulation_enable_control(en),
    .mode_select_high(sel_hi), .mode_select_low(sel_lo), .port_power_enable(pwr),
    .bus_load_current(load), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .port_switch_closed(sw),
    .vbus_discharge_on(dis), .line_drive(drv), .hs_switch_closed(hs),
    .cc_limit_mode(cc));

  cemseq_dev_model u_dev (
    .core_clk(core_clk), .line_drive(drv), .port_switch_closed(sw),
    .attached(attached), .accept_prof(accept_prof), .bus_load_current(load));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  //////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic hang();
    errors++;
    $display("[ERR] wait limit exp 1 got 0");
    close_out();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    wr = 1'b1;
    addr = a;
    wdata = d;
    cyc(1);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    cyc(1);
    rd = 1'b1;
    addr = a;
    cyc(1);
    rd = 1'b0;
    d = rdata;
  endtask

  // wait for a profile to be applied, watching the emulation reset before it
  task automatic wait_rise(output logic [3:0] prof);
    logic pd;
    logic ds;
    int   n;
    pd = 1'b0;
    ds = 1'b0;
    n = 0;
    while (drv.sig_valid !== 1'b1) begin
      pd |= drv.pulldown_on & !sw;
      ds |= dis;
      cyc(1);
      n++;
      if (n > 3000) hang();
    end
    prof = drv.profile;
    `CHK("reset pulldown", 1'b1, pd)
    `CHK("discharge", 1'b1, ds)
    `CHK("switch closed", 1'b1, sw)
  endtask

  task automatic wait_fall(output int len);
    len = 0;
    while (drv.sig_valid === 1'b1) begin
      cyc(1);
      len++;
      if (len > 3000) hang();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] adr [6] = '{8'h16, 8'h25, 8'h40, 8'h51, 8'h12, 8'h7F};
    logic [7:0] exv [6] = '{8'h03, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd_reg(adr[i], d);
      `CHK("reset value", exv[i], d)
    end
    `CHK("idle drive", 7'h00, drv)
    $display("test regs done");
  endtask

  task automatic t_nohs();
    logic [3:0] p;
    logic [7:0] d;
    int         len;
    int         code [2] = '{1, 3};
    int         ex;
    wr_reg(8'h16, 8'h02);
    wr_reg(8'h30, 8'h31);
    wr_reg(8'h17, 8'h03);
    wr_reg(8'h51, 8'h14);
    pwr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wait_rise(p);
      `CHK("profile order", i[3:0], p)
      `CHK("short on", (i == 1 || i == 2), drv.charger_short_on)
      `CHK("hs open", 1'b0, hs)
      `CHK("apply cc", 1'b1, cc)
      wait_fall(len);
      if (i < 2) begin
        ex = (code[i] + 1) * UNIT * TK;
        `CHK("apply time", 1'b1, (len > ex - TK && len <= ex + 1))
      end
    end
    cyc(20);
    rd_reg(8'h12, d);
    `CHK("no handshake", 1'b1, d[0])
    `CHK("signatures off", 1'b0, drv.sig_valid)
    `CHK("nohs cc", 1'b1, cc)
    `CHK("nohs switch", 1'b1, sw)
    wr_reg(8'h12, 8'h00);
    rd_reg(8'h12, d);
    `CHK("flag holds", 1'b1, d[0])
    wr_reg(8'h25, 8'h01);
    cyc(3);
    `CHK("hs config", 1'b1, hs)
    wr_reg(8'h51, 8'h08);
    cyc(3);
    `CHK("nohs trip", 1'b0, cc)
    pwr = 1'b0;
    cyc(3);
    `CHK("abort drive", 7'h00, drv)
    `CHK("abort switch", 1'b0, sw)
    wr_reg(8'h16, 8'h03);
    wr_reg(8'h25, 8'h00);
    wr_reg(8'h17, 8'h07);
    $display("test no handshake done");
  endtask

  task automatic t_retry_dcp();
    logic [3:0] p;
    logic [7:0] d;
    int         len;
    pwr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wait_rise(p);
      wait_fall(len);
    end
    wait_rise(p);
    `CHK("retry restart", 4'h0, p)
    attached = 1'b1;
    accept_prof = 4'h1;
    wait_fall(len);
    wait_rise(p);
    cyc(40);
    rd_reg(8'h12, d);
    `CHK("dcp accepted", 8'h16, d)
    `CHK("dcp short kept", 1'b1, drv.charger_short_on)
    `CHK("dcp hs open", 1'b0, hs)
    `CHK("dcp cc", 1'b1, cc)
    cyc(60);
    `CHK("no more profiles", 7'h51, drv)
    pwr = 1'b0;
    cyc(3);
    $display("test retry and dcp done");
  endtask

  task automatic t_custom_first();
    logic [3:0] p;
    logic [7:0] d;
    wr_reg(8'h40, 8'h31);
    accept_prof = 4'h8;
    pwr = 1'b1;
    wait_rise(p);
    `CHK("custom first", 4'h8, p)
    cyc(30);
    rd_reg(8'h12, d);
    `CHK("custom accepted", 8'h84, d)
    `CHK("custom trip", 1'b0, cc)
    pwr = 1'b0;
    attached = 1'b0;
    wr_reg(8'h40, 8'h03);
    $display("test custom first done");
  endtask

  // timeout disabled: first profile stays applied, accepted-row limit mode
  task automatic t_no_timeout();
    logic [3:0] p;
    wr_reg(8'h16, 8'h01);
    pwr = 1'b1;
    wait_rise(p);
    cyc(100);
    `CHK("no timeout hold", 1'b1, drv.sig_valid)
    `CHK("no timeout prof", 4'h0, drv.profile)
    `CHK("no timeout cc", 1'b0, cc)
    pwr = 1'b0;
    cyc(3);
    wr_reg(8'h16, 8'h03);
    $display("test no timeout done");
  endtask

  task automatic t_modes();
    logic [2:0] cmb [4] = '{3'b100, 3'b110, 3'b011, 3'b111};
    int         n;
    for (int i = 0; i < 4; i++) begin
      {en, sel_hi, sel_lo} = cmb[i];
      pwr = 1'b1;
      n = 0;
      while (drv.sig_valid !== 1'b1 && n < 80) begin
        cyc(1);
        n++;
      end
      `CHK("mode run", cmb[i][2] & !(cmb[i][1] & cmb[i][0]), (n < 80))
      pwr = 1'b0;
      cyc(3);
    end
    {en, sel_hi, sel_lo} = 3'b100;
    $display("test modes done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(16);
    srst = 1'b0;
    t_regs();
    t_nohs();
    t_retry_dcp();
    t_custom_first();
    t_no_timeout();
    t_modes();
    close_out();
  end
endmodule

`default_nettype wire
